// ### rto_core.sv
// Counter, prescaler, trigger detection and output pulse of the reload timer
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module rto_core (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tinSync,
   rto_ctl_if.core ctl,
   output logic tout
);
   rto_pkg::rto_state_t state;     // Counter state
   rto_pkg::rto_state_t next_state; // Next counter state
   logic [6:0] preCnt;             // Prescale counter
   logic [15:0] count;             // Timer count
   logic tinPrev;                  // Previous synchronised input
   logic pulse;                    // Output pulse flag, one cycle
   // Decoded configuration
   wire enable = ctl.ctrl[rto_pkg::CTRL_EN];
   wire trigMode = ctl.ctrl[rto_pkg::CTRL_MODE] == rto_pkg::RTO_TRIGGERED;
   wire pol = ctl.ctrl[rto_pkg::CTRL_POL];
   wire outEn = ctl.ctrl[rto_pkg::CTRL_OUTEN];
   wire [6:0] preLast = rto_pkg::rto_pre_last(ctl.ctrl[rto_pkg::CTRL_PRE_HI:rto_pkg::CTRL_PRE_LO]);
   // Edge selected by polarity: rising when zero, falling when one
   wire trigEdge = pol ? (tinPrev & ~tinSync) : (~tinPrev & tinSync);
   wire running = (state == rto_pkg::RTO_COUNT) & enable;
   wire tick = running & (preCnt == preLast);
   wire atReload = tick & (count == ctl.reload);
   wire trigTake = (state == rto_pkg::RTO_ARMED) & enable & trigEdge;
   assign ctl.count = count;
   assign ctl.reloadHit = atReload;
   assign ctl.trigHit = trigTake;
   assign ctl.enClear = atReload & ~trigMode;
   // Output idles at polarity level and inverts during the reload pulse
   assign tout = outEn ? (pol ^ pulse) : pol;
   // State selection
   always_comb begin
      next_state = state;
      case (state)
         rto_pkg::RTO_IDLE: begin
            if (enable) begin
               next_state = trigMode ? rto_pkg::RTO_ARMED : rto_pkg::RTO_COUNT;
            end
         end
         rto_pkg::RTO_ARMED: begin
            if (!enable) begin
               next_state = rto_pkg::RTO_IDLE;
            end else if (trigTake) begin
               next_state = rto_pkg::RTO_COUNT;
            end
         end
         rto_pkg::RTO_COUNT: begin
            if (!enable) begin
               next_state = rto_pkg::RTO_IDLE;
            end else if (atReload) begin
               // Triggered returns to wait; one-shot stops
               next_state = trigMode ? rto_pkg::RTO_ARMED : rto_pkg::RTO_IDLE;
            end
         end
         default: begin
            next_state = rto_pkg::RTO_IDLE;
         end
      endcase
   end
   // State, prescaler and edge history
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= rto_pkg::RTO_IDLE;
         preCnt <= rto_pkg::PRE_ZERO;
         tinPrev <= 1'b0;
         pulse <= 1'b0;
      end else begin
         state <= next_state;
         tinPrev <= tinSync;
         pulse <= atReload;
         // Prescaler restarts when not counting or at each tick
         preCnt <= (!running || tick) ? rto_pkg::PRE_ZERO : preCnt + rto_pkg::PRE_ONE;
      end
   end
   // Count: software load, reload restart, or wrapping increment
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= rto_pkg::CNT_START;
      end else if (ctl.cntWrite) begin
         count <= ctl.cntWdata;
      end else if (atReload) begin
         count <= rto_pkg::CNT_START;
      end else if (tick) begin
         count <= count + rto_pkg::CNT_ONE;
      end
   end
   // Output pulse lasts exactly one cycle after reload
   chk_pulse_one: assert property (@(posedge clk) disable iff (!nrst)
      pulse |=> !pulse) else $error("output pulse longer than one cycle");
   chk_reload_restart: assert property (@(posedge clk) disable iff (!nrst)
      atReload && !ctl.cntWrite |=> count == rto_pkg::CNT_START) else $error("count not restarted");
   chk_oneshot_stop: assert property (@(posedge clk) disable iff (!nrst)
      atReload && !trigMode |=> state == rto_pkg::RTO_IDLE) else $error("one-shot kept counting");
   chk_trig_rearm: assert property (@(posedge clk) disable iff (!nrst)
      atReload && trigMode && enable |=> state == rto_pkg::RTO_ARMED) else $error("not rearmed");
   chk_armed_hold: assert property (@(posedge clk) disable iff (!nrst)
      state == rto_pkg::RTO_ARMED && !trigEdge && !ctl.cntWrite |=> $stable(count)) else $error("armed counted");
   chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
      tick && !atReload && !ctl.cntWrite |=> count == $past(count) + rto_pkg::CNT_ONE) else $error("bad step");
   chk_pre_wait: assert property (@(posedge clk) disable iff (!nrst)
      running && preCnt != preLast && !ctl.cntWrite |=> $stable(count)) else $error("counted early");
   chk_out_pol: assert property (@(posedge clk) disable iff (!nrst)
      atReload && outEn ##1 outEn && $stable(pol) |-> tout != pol) else $error("output not inverted");
   chk_min_delay: assert property (@(posedge clk) disable iff (!nrst)
      running && preLast == rto_pkg::PRE_ZERO && count == ctl.reload |-> atReload) else $error("minimum delay missed");
   cov_oneshot: cover property (@(posedge clk) atReload && !trigMode);
   cov_trig: cover property (@(posedge clk) trigTake ##[1:50] atReload);
   cov_wrap: cover property (@(posedge clk) tick && count == 16'hFFFF);
endmodule : rto_core

// ### rto_pkg.sv
// Package with register map, field layout and constants of the reload timer
package rto_pkg;
   // Register byte offsets (one aligned word each)
   localparam logic [7:0] ADDR_CTRL = 8'h00;   // Control register
   localparam logic [7:0] ADDR_COUNT = 8'h04;  // Count high/low bytes
   localparam logic [7:0] ADDR_RELOAD = 8'h08; // Reload high/low bytes
   localparam logic [7:0] ADDR_STATUS = 8'h0C; // Sticky event status, write one to clear
   localparam logic [7:0] ADDR_MASK = 8'h10;   // Interrupt mask
   // Control register field positions
   localparam int CTRL_EN = 0;      // Timer enable
   localparam int CTRL_MODE = 1;    // 0 one-shot, 1 triggered one-shot
   localparam int CTRL_POL = 2;     // Output polarity bit
   localparam int CTRL_OUTEN = 3;   // Output function enable
   localparam int CTRL_PRE_LO = 4;  // Prescale select, low bit
   localparam int CTRL_PRE_HI = 6;  // Prescale select, high bit
   localparam int CTRL_W = 7;       // Width of the control register
   // Status / mask bit positions
   localparam int ST_RELOAD = 0;    // Reload reached
   localparam int ST_TRIG = 1;      // Trigger edge accepted
   localparam int ST_W = 2;         // Width of status and mask
   // Counter constants
   localparam logic [15:0] CNT_START = 16'h0001; // Count after reload and reset
   localparam logic [15:0] CNT_ONE = 16'h0001;   // Increment step
   localparam logic [6:0] PRE_ONE = 7'h01;       // Prescale counter step
   localparam logic [6:0] PRE_ZERO = 7'h00;      // Prescale counter restart
   // Operating modes
   typedef enum logic {
      RTO_ONESHOT = 1'b0,
      RTO_TRIGGERED = 1'b1
   } rto_mode_t;
   // Counter states
   typedef enum logic [1:0] {
      RTO_IDLE = 2'b00,
      RTO_ARMED = 2'b01,
      RTO_COUNT = 2'b10
   } rto_state_t;
   // Prescale divisor minus one for a select code 0..7 (divide 1..128)
   function automatic logic [6:0] rto_pre_last(input logic [2:0] sel);
      rto_pre_last = 7'((8'h01 << sel) - 8'h01);
   endfunction : rto_pre_last
endpackage : rto_pkg

// ### rto_ctl_if.sv
// Interface that carries configuration and events between the bus slave and the counter
`timescale 1ns/1ps
interface rto_ctl_if;
   logic [6:0] ctrl;        // Control register contents
   logic [15:0] reload;     // Reload value
   logic [15:0] count;      // Current count, from the counter
   logic cntWrite;          // One-cycle pulse: software loads the count
   logic [15:0] cntWdata;   // Count value to load
   logic enClear;           // One-cycle pulse: counter clears the enable
   logic reloadHit;         // One-cycle pulse: reload reached
   logic trigHit;           // One-cycle pulse: trigger edge accepted
   modport regs (output ctrl, reload, cntWrite, cntWdata, input count, enClear, reloadHit, trigHit);
   modport core (input ctrl, reload, cntWrite, cntWdata, output count, enClear, reloadHit, trigHit);
endinterface : rto_ctl_if

// ### rto_sync.sv
// Two-flip-flop synchroniser for the timer input pin
`timescale 1ns/1ps
module rto_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic din,
   output logic dout
);
   logic stage1; // First stage, read only by the second
   // Two flops in series
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : rto_sync

// ### reload_timer_one_shot.sv
// Top of the reload timer: AHB-Lite register slave, interrupt logic and counter core
`timescale 1ns/1ps
module reload_timer_one_shot (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic timerIn,
   output logic timerOut,
   output logic irq
);
   rto_ctl_if ctl ();                // Link between registers and counter
   logic [rto_pkg::CTRL_W-1:0] ctrl; // Control register
   logic [15:0] reload;              // Reload value
   logic [rto_pkg::ST_W-1:0] status; // Sticky event bits
   logic [rto_pkg::ST_W-1:0] mask;   // Interrupt mask
   logic wrPend;                     // Write data phase pending
   logic [7:0] wrAddr;               // Latched write address
   logic [31:0] rdData;              // Read data register
   logic tinSync;                    // Synchronised input pin
   // Address phase decode
   wire addrValid = hsel & hready & htrans[1];
   wire rdTake = addrValid & ~hwrite;
   wire wrTake = addrValid & hwrite;
   // Write decode in the data phase
   wire wrCtrl = wrPend & (wrAddr == rto_pkg::ADDR_CTRL);
   wire wrCount = wrPend & (wrAddr == rto_pkg::ADDR_COUNT);
   wire wrReload = wrPend & (wrAddr == rto_pkg::ADDR_RELOAD);
   wire wrStatus = wrPend & (wrAddr == rto_pkg::ADDR_STATUS);
   wire wrMask = wrPend & (wrAddr == rto_pkg::ADDR_MASK);
   wire [rto_pkg::ST_W-1:0] events = {ctl.trigHit, ctl.reloadHit};
   // Read selection, unmapped reads as zero
   wire [7:0] rdAddr = haddr[7:0];
   wire [31:0] rdMux =
      (rdAddr == rto_pkg::ADDR_CTRL) ? {25'h0000000, ctrl} :
      (rdAddr == rto_pkg::ADDR_COUNT) ? {16'h0000, ctl.count} :
      (rdAddr == rto_pkg::ADDR_RELOAD) ? {16'h0000, reload} :
      (rdAddr == rto_pkg::ADDR_STATUS) ? {30'h00000000, status} :
      (rdAddr == rto_pkg::ADDR_MASK) ? {30'h00000000, mask} : 32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdData;
   assign ctl.ctrl = ctrl;
   assign ctl.reload = reload;
   assign ctl.cntWrite = wrCount;
   assign ctl.cntWdata = hwdata[15:0];
   assign irq = |(status & mask);
   // Bus address phase capture and read data
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         rdData <= 32'h00000000;
      end else begin
         wrPend <= wrTake;
         wrAddr <= haddr[7:0];
         rdData <= rdTake ? rdMux : rdData;
      end
   end
   // Control: software write, counter clears enable after one-shot
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= '0;
      end else if (wrCtrl) begin
         ctrl <= hwdata[rto_pkg::CTRL_W-1:0];
      end else if (ctl.enClear) begin
         ctrl[rto_pkg::CTRL_EN] <= 1'b0;
      end
   end
   // Reload, mask and sticky status; a new event wins over its clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reload <= 16'h0000;
         mask <= '0;
         status <= '0;
      end else begin
         reload <= wrReload ? hwdata[15:0] : reload;
         mask <= wrMask ? hwdata[rto_pkg::ST_W-1:0] : mask;
         status <= (status & ~(wrStatus ? hwdata[rto_pkg::ST_W-1:0] : '0)) | events;
      end
   end
   // Input pin synchroniser
   rto_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .din(timerIn),
      .dout(tinSync)
   );
   // Counter core
   rto_core u_core (
      .clk(clk),
      .nrst(nrst),
      .tinSync(tinSync),
      .ctl(ctl),
      .tout(timerOut)
   );
   chk_irq_sticky: assert property (@(posedge clk) disable iff (!nrst)
      ctl.reloadHit |=> status[rto_pkg::ST_RELOAD]) else $error("reload event lost");
   chk_enable_clear: assert property (@(posedge clk) disable iff (!nrst)
      ctl.enClear && !wrCtrl |=> !ctrl[rto_pkg::CTRL_EN]) else $error("enable not cleared");
   cov_irq: cover property (@(posedge clk) irq);
endmodule : reload_timer_one_shot

// ### rto_pin_model.sv
// Model of the trigger source and of the load on the timer pins
`timescale 1ns/1ps
module rto_pin_model (
   input wire logic clk,
   input wire logic clr,
   input wire logic restLvl,
   input wire logic timerOut,
   output logic timerIn
);
   int offCycles; // Cycles seen away from the rest level
   int edges; // Level changes seen on the output pin
   logic lastOut; // Output level at the previous edge
   // Input pin starts low
   initial begin
      timerIn = 1'h0;
   end
   // Sample the output pin once per clock, as a clocked load would
   always @(posedge clk) begin
      if (clr) begin
         offCycles = 0;
         edges = 0;
      end else begin
         if (timerOut !== restLvl) offCycles++;
         if (timerOut !== lastOut) edges++;
      end
      lastOut = timerOut;
   end
   // Move the input pin just after an edge and hold it a full cycle
   task automatic drive(input logic v);
      @(posedge clk);
      timerIn <= v;
   endtask : drive
endmodule : rto_pin_model

// ### reload_timer_one_shot_test.sv
// Self-checking testbench of the reload timer in its one-shot modes
`timescale 1ns/1ps
module reload_timer_one_shot_test;
   logic clk = 1'h0; // System clock, 20 ns
   logic nrst; // Synchronous reset, active low
   logic [31:0] haddr; // Bus address
   logic [1:0] htrans; // Transfer kind
   logic hwrite; // Write strobe
   logic [31:0] hwdata; // Write data
   logic [31:0] hrdata; // Read data
   logic hreadyout; // Slave ready, also the bus ready
   logic hresp; // Slave response, always OKAY
   logic timerIn; // Trigger pin
   logic timerOut; // Output pin
   logic irq; // Interrupt line
   logic clr; // Clears the pin model counters
   logic restLvl; // Output level between pulses
   int mismatches; // Failed comparisons
   int checks; // Comparisons made
   int cyc; // Cycles since start
   int n; // Measured delay
   int e; // Expected delay
   // Clock generator
   always #10 clk = ~clk;
   reload_timer_one_shot reload_timer_one_shot_i (.clk(clk), .nrst(nrst), .hsel(1'h1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timerIn(timerIn), .timerOut(timerOut), .irq(irq));
   rto_pin_model rto_pin_model_i (.clk(clk), .clr(clr), .restLvl(restLvl),
      .timerOut(timerOut), .timerIn(timerIn));
   // Compare and count
   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] g);
      checks++;
      if (g !== ex) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, ex, g);
      end
   endtask : check
   // One bus transfer: address phase, then data phase
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
   endtask : xfer
   // Read a register and compare it
   task automatic busRead(input logic [7:0] a, input logic [31:0] ex, input string nm);
      xfer(a, 1'h0, 32'h00000000);
      check(nm, ex, hrdata);
   endtask : busRead
   // Load a disabled setup, clear events, then start with the given control word
   task automatic start(input logic [31:0] c, input logic [31:0] cnt, input logic [31:0] r);
      xfer(rto_pkg::ADDR_CTRL, 1'h1, c & 32'hFFFFFFFE);
      xfer(rto_pkg::ADDR_COUNT, 1'h1, cnt);
      xfer(rto_pkg::ADDR_RELOAD, 1'h1, r);
      xfer(rto_pkg::ADDR_STATUS, 1'h1, 32'h00000003);
      clr <= 1'h1;
      @(posedge clk);
      clr <= 1'h0;
      xfer(rto_pkg::ADDR_CTRL, 1'h1, c);
   endtask : start
   // Count cycles until the interrupt or an output excursion shows
   task automatic waitFor(input logic onPin, output int k);
      k = 0;
      while ((onPin ? timerOut === restLvl : irq !== 1'h1) && k < 3000) begin
         @(posedge clk);
         k++;
      end
   endtask : waitFor
   // Final report and verdict
   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         mismatches++;
         results();
      end
   end
   // Main sequence
   initial begin
      nrst = 1'h0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hwdata = 32'h00000000;
      clr = 1'h1;
      restLvl = 1'h0;
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      busRead(rto_pkg::ADDR_CTRL, 32'h00000000, "ctrl");
      busRead(rto_pkg::ADDR_COUNT, 32'h00000001, "count");
      busRead(8'h14, 32'h00000000, "unmapped");
      check("irq", 32'h00000000, {31'h0, irq});
      check("hresp", 32'h00000000, {31'h0, hresp});
      $display("test reset done");
      // Shortest timeout, pulse and interrupt
      xfer(rto_pkg::ADDR_MASK, 1'h1, 32'h00000003);
      start(32'h00000009, 32'h00000001, 32'h00000001);
      waitFor(1'h0, n);
      check("short", 32'h00000001, {31'h0, n <= 4});
      busRead(rto_pkg::ADDR_CTRL, 32'h00000008, "selfstop");
      busRead(rto_pkg::ADDR_COUNT, 32'h00000001, "restart");
      busRead(rto_pkg::ADDR_STATUS, 32'h00000001, "status");
      check("pulse", 32'h00000001, 32'(rto_pin_model_i.offCycles));
      check("edges", 32'h00000002, 32'(rto_pin_model_i.edges));
      xfer(rto_pkg::ADDR_STATUS, 1'h1, 32'h00000001);
      busRead(rto_pkg::ADDR_STATUS, 32'h00000000, "cleared");
      check("irqoff", 32'h00000000, {31'h0, irq});
      $display("test shortest done");
      // Every prescale, with a polarity flip after start
      for (int k = 0; k < 8; k++) begin
         start(32'h00000009 | (k << 4), 32'h00000001, 32'h00000005);
         xfer(rto_pkg::ADDR_CTRL, 1'h1, 32'h0000000D | (k << 4));
         waitFor(1'h0, n);
         e = 5 << k;
         check("period", 32'h00000001, {31'h0, n + 2 >= e - 1 && n + 2 <= e + 3});
         busRead(rto_pkg::ADDR_CTRL, 32'h0000000C | (k << 4), "stopped");
         check("level", 32'h00000001, {31'h0, timerOut});
      end
      $display("test prescale done");
      // Start above the reload value: wrap through zero first
      start(32'h00000001, 32'h0000FFFE, 32'h00000002);
      waitFor(1'h0, n);
      check("wrap", 32'h00000001, {31'h0, n >= 3 && n <= 7});
      busRead(rto_pkg::ADDR_COUNT, 32'h00000001, "wrapcount");
      check("quiet", 32'h00000000, 32'(rto_pin_model_i.edges));
      xfer(rto_pkg::ADDR_MASK, 1'h1, 32'h00000002);
      busRead(rto_pkg::ADDR_STATUS, 32'h00000001, "maskedstatus");
      check("masked", 32'h00000000, {31'h0, irq});
      $display("test wrap done");
      // Triggered mode, rising then falling trigger edge
      for (int p = 0; p < 2; p++) begin
         restLvl <= p[0];
         rto_pin_model_i.drive(p[0]);
         start(32'h0000000B | (p << 2), 32'h00000001, 32'h0000000A);
         repeat (20) @(posedge clk);
         busRead(rto_pkg::ADDR_COUNT, 32'h00000001, "armed");
         busRead(rto_pkg::ADDR_STATUS, 32'h00000000, "notrig");
         rto_pin_model_i.drive(!p[0]);
         repeat (2) @(posedge clk);
         rto_pin_model_i.drive(p[0]);
         rto_pin_model_i.drive(!p[0]);
         waitFor(1'h1, n);
         check("trigdelay", 32'h00000001, {31'h0, n + 5 >= 11 && n + 5 <= 16});
         repeat (5) @(posedge clk);
         check("tpulse", 32'h00000001, 32'(rto_pin_model_i.offCycles));
         check("tedges", 32'h00000002, 32'(rto_pin_model_i.edges));
         busRead(rto_pkg::ADDR_STATUS, 32'h00000003, "tstatus");
         busRead(rto_pkg::ADDR_COUNT, 32'h00000001, "tcount");
         rto_pin_model_i.drive(p[0]);
         rto_pin_model_i.drive(!p[0]);
         repeat (25) @(posedge clk);
         check("rearm", 32'h00000002, 32'(rto_pin_model_i.offCycles));
      end
      $display("test triggered done");
      results();
   end
endmodule : reload_timer_one_shot_test
